// file: rtl/phy_cfg_pkg.sv
// shared constants and carrier types for the phy configuration and clocking block
package phy_cfg_pkg;

	// line rates in kbit/s
	localparam int unsigned RATE_S100_KBPS  = 98304;
	localparam int unsigned RATE_S200_KBPS  = 196608;
	localparam int unsigned RATE_S400_KBPS  = 393216;
	localparam int unsigned RATE_S400B_KBPS = 491520;
	localparam int unsigned RATE_S800_KBPS  = 983040;

	// crystal reference and system clock in kHz
	localparam int unsigned XTAL_KHZ    = 98304;
	localparam int unsigned SYS_CLK_KHZ = 100000;

	// pll lock settle time and its count in sys_clk cycles (least time, rounded up)
	localparam int unsigned PLL_LOCK_NS     = 1000;
	localparam int unsigned SYS_CLK_NS      = 10;
	localparam int unsigned PLL_LOCK_CYCLES = (PLL_LOCK_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
	localparam int          LOCK_CNT_W      = 8;

	// pin synchroniser depth in sys_clk cycles
	localparam int unsigned SYNC_STAGES     = 2;

	// speed codes
	typedef enum logic [2:0] {
		SPD_S100  = 3'h0,
		SPD_S200  = 3'h1,
		SPD_S400  = 3'h2,
		SPD_S400B = 3'h3,
		SPD_S800  = 3'h4
	} speed_t;

	// serialiser word width (the per-speed shift divider is tick_div in phy_cfg_clk)
	localparam int DATA_W = 8;

	// pll state machine, gray along off -> lock -> run
	typedef enum logic [1:0] {
		PLL_OFF  = 2'h0,
		PLL_LOCK = 2'h1,
		PLL_RUN  = 2'h3
	} pll_state_t;

	// phy register bit positions of the writable control byte
	localparam int CONTENDER_BIT = 0;
	localparam int EVENT_BIT     = 1;
	localparam logic CONTENDER_RST = 1'h0;

	// strap carrier
	typedef struct packed {
		logic beta_interface_select;
		logic [2:0] power_class;
	} strap_t;

	// write carrier: set-on-one and clear-on-one strobes
	typedef struct packed {
		logic       wr;
		logic [7:0] set_ones;
		logic [7:0] clr_ones;
	} reg_wr_t;

endpackage

// file: rtl/pin_sync.sv
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module pin_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         sys_clk,
	input  wire logic         sys_rst,
	// pins in, synchronised out
	input  wire logic [W-1:0] pin_in,
	output logic      [W-1:0] pin_out
);

	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= pin_in;
			sync_q <= meta_q;
		end
	end

	assign pin_out = sync_q;

endmodule

// file: rtl/phy_cfg_clk.sv
// phy configuration, strap capture, pll control and outbound serialiser
//
// What this block does
// R1: transmit clock derives from a pll fed by the 98.304 MHz crystal.
// R2: pwrdn_pin high halts the pll and stops outbound transmit clocks.
// R3: latch outbound byte, serialise, encode, send at S100 to S800 rate; S400B and S800 shift every tick, as S400 does.
// R4: beta_interface_select picks phy-link mode and arbitration, not cable mode.
// R5: the system holds beta_interface_select high in normal operation.
// R6: three power-class straps give the self-id power-class default.
// R7: contender bit has no strap; it becomes set only by software write.
// R8: software writes contender to one to contend for manager roles.
// R9: clear-on-one fields clear on a written one; zero leaves them unchanged.
// R10: set-on-one fields set on a written one; zero has no effect.
// R11: names ending _n are active low, asserted at logic zero.
`timescale 1ns/1ps
module phy_cfg_clk
	import phy_cfg_pkg::*;
(
	// clock and reset
	input  wire logic              sys_clk,
	input  wire logic              sys_rst,
	// crystal-derived reference, pll and power down pins
	input  wire logic              xtal_ok,
	input  wire logic              pwrdn_pin,
	// straps
	input  wire logic              beta_interface_select,
	input  wire logic              power_class_strap_bit0,
	input  wire logic              power_class_strap_bit1,
	input  wire logic              power_class_strap_bit2,
	// software and hardware access to the control byte
	input  wire reg_wr_t           sw_wr,
	input  wire logic              event_hw_set,
	// outbound data from the link side
	input  wire logic              tx_valid,
	input  wire logic [DATA_W-1:0] tx_data,
	input  wire speed_t            tx_speed,
	// status and line
	output logic                   tx_ready,
	output logic                   tx_line,
	output logic                   tx_clk_en,
	output logic                   pll_locked,
	output logic                   pll_run_n,
	output logic [7:0]             ctrl_reg,
	output logic [2:0]             self_id_power_class,
	output logic                   beta_mode,
	output speed_t                 line_speed
);

	typedef struct packed {
		pll_state_t              pll;
		logic [LOCK_CNT_W-1:0]   lock_cnt;
		logic [1:0]              sync_age;
		logic                    strap_done;
		strap_t                  straps;
		logic [7:0]              ctrl;
		logic [DATA_W-1:0]       shift;
		logic [3:0]              bits_left;
		logic                    busy;
		logic                    line;
		speed_t                  speed;
		logic [2:0]              tick_cnt;
		logic                    ready;
		logic                    clk_en;
		logic                    locked;
		logic                    run_n;
	} state_t;

	state_t st_q;
	state_t st_d;
	logic [1:0] clk_pins_s;
	logic [3:0] strap_pins_s;
	logic xtal_s;
	logic pwrdn_s;
	strap_t strap_s;
	logic [2:0] tick_div;

	// crystal and power-down pins
	pin_sync #(.W(2)) u_sync_clk (
		.sys_clk (sys_clk),
		.sys_rst (sys_rst),
		.pin_in  ({xtal_ok, pwrdn_pin}),
		.pin_out (clk_pins_s)
	);

	// strap pins
	pin_sync #(.W(4)) u_sync_strap (
		.sys_clk (sys_clk),
		.sys_rst (sys_rst),
		.pin_in  ({beta_interface_select, power_class_strap_bit2,
			power_class_strap_bit1, power_class_strap_bit0}),
		.pin_out (strap_pins_s)
	);

	assign xtal_s  = clk_pins_s[1];
	assign pwrdn_s = clk_pins_s[0];
	assign strap_s = strap_t'(strap_pins_s);

	// sys_clk ticks per bit, less one; S400 and faster rates shift on every tick
	always_comb begin
		case (st_q.speed)
			SPD_S100:  tick_div = 3'h3;
			SPD_S200:  tick_div = 3'h1;
			SPD_S400:  tick_div = 3'h0;
			SPD_S400B: tick_div = 3'h0;
			SPD_S800:  tick_div = 3'h0;
			default:   tick_div = 3'h0;
		endcase
	end

	always_comb begin
		st_d = st_q;

		// pll runs only from a live crystal and with power down low
		case (st_q.pll)
			// halted: wait for a live crystal and power down released
			PLL_OFF: begin
				st_d.lock_cnt = '0;
				if (xtal_s && !pwrdn_s) begin // see R1
					st_d.pll = PLL_LOCK;
				end
			end
			// settling: count the lock time
			PLL_LOCK: begin
				if (pwrdn_s || !xtal_s) begin // see R2
					st_d.pll = PLL_OFF;
				end else if (st_q.lock_cnt == LOCK_CNT_W'(PLL_LOCK_CYCLES - 1)) begin
					st_d.pll = PLL_RUN;
				end else begin
					st_d.lock_cnt = st_q.lock_cnt + 1'b1;
				end
			end
			// locked: transmit clock runs
			PLL_RUN: begin
				if (pwrdn_s || !xtal_s) begin // see R2
					st_d.pll = PLL_OFF;
				end
			end
			default: st_d.pll = PLL_OFF;
		endcase

		// the synchroniser flops leave reset at zero, so straps are
		// caught only once real pin levels have crossed both stages
		if (st_q.sync_age != 2'(SYNC_STAGES)) begin
			st_d.sync_age = st_q.sync_age + 1'b1;
		end else if (!st_q.strap_done) begin
			st_d.straps     = strap_s; // see R6
			st_d.strap_done = 1'b1;
		end else begin
			st_d.straps.beta_interface_select = strap_s.beta_interface_select; // see R4
		end

		// control byte: set-on-one then clear-on-one, hardware set wins over clear
		if (sw_wr.wr) begin
			// zero bits in either mask leave the byte alone
			st_d.ctrl = st_q.ctrl | sw_wr.set_ones; // see R10 see R7
			st_d.ctrl = st_d.ctrl & ~sw_wr.clr_ones; // see R9
		end
		// a same-cycle clear loses to the hardware event
		if (event_hw_set) begin
			st_d.ctrl[EVENT_BIT] = 1'b1;
		end

		// serialiser with nrzi-style encoding
		if (st_q.pll != PLL_RUN) begin
			st_d.busy      = 1'b0; // see R2
			st_d.shift     = '0;
			st_d.bits_left = '0;
			st_d.tick_cnt  = '0;
		end else if (!st_q.busy) begin
			if (tx_valid) begin // see R3
				st_d.shift     = tx_data;
				st_d.bits_left = 4'(DATA_W);
				st_d.busy      = 1'b1;
				st_d.speed     = tx_speed;
				st_d.tick_cnt  = '0;
			end
		end else if (st_q.tick_cnt == tick_div) begin
			st_d.tick_cnt  = '0;
			st_d.line      = st_q.line ^ st_q.shift[DATA_W-1]; // see R3
			st_d.shift     = {st_q.shift[DATA_W-2:0], 1'b0};
			st_d.bits_left = st_q.bits_left - 1'b1;
			if (st_q.bits_left == 4'h1) begin
				st_d.busy = 1'b0;
			end
		end else begin
			st_d.tick_cnt = st_q.tick_cnt + 1'b1;
		end

		// status flags are registered so that every output leaves a flip-flop
		st_d.clk_en = (st_d.pll == PLL_RUN); // see R1
		st_d.locked = (st_d.pll == PLL_RUN);
		st_d.run_n  = (st_d.pll != PLL_RUN); // see R11
		st_d.ready  = (st_d.pll == PLL_RUN) && !st_d.busy;
	end

	// synchronous reset; the active-low run flag idles high
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			st_q       <= '0;
			st_q.run_n <= 1'b1;
			st_q.pll   <= PLL_OFF;
			st_q.speed <= SPD_S100;
			st_q.ctrl  <= '0;
			st_q.ctrl[CONTENDER_BIT] <= CONTENDER_RST; // see R7
		end else begin
			st_q <= st_d;
		end
	end

	// outputs all from state flip-flops
	assign tx_ready            = st_q.ready;
	assign tx_line             = st_q.line;
	assign tx_clk_en           = st_q.clk_en;
	assign pll_locked          = st_q.locked;
	assign pll_run_n           = st_q.run_n; // see R11
	assign ctrl_reg            = st_q.ctrl;
	assign self_id_power_class = st_q.straps.power_class;
	assign beta_mode           = st_q.straps.beta_interface_select;
	assign line_speed          = st_q.speed;

endmodule

// file: sim/phy_cfg_clk_chk.sv
// assertion checker on the ports of the configuration and clocking block
`timescale 1ns/1ps
module phy_cfg_clk_chk
	import phy_cfg_pkg::*;
(
	input wire logic    sys_clk,
	input wire logic    sys_rst,
	input wire logic    pwrdn_pin,
	input wire logic    beta_interface_select,
	input wire reg_wr_t sw_wr,
	input wire logic    event_hw_set,
	input wire logic    tx_valid,
	input wire speed_t  tx_speed,
	input wire logic    tx_ready,
	input wire logic    tx_clk_en,
	input wire logic    pll_locked,
	input wire logic    pll_run_n,
	input wire logic    [7:0] ctrl_reg,
	input wire logic    beta_mode,
	input wire speed_t  line_speed
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	sequence s_take;
		tx_valid && tx_ready;
	endsequence
	sequence s_quiet0;
		!(sw_wr.wr && (sw_wr.set_ones[0] || sw_wr.clr_ones[0]));
	endsequence
	a_run_flag: assert property (pll_run_n != pll_locked)
		else $error("run flag not inverse of lock");
	a_clk_lock: assert property (tx_clk_en == pll_locked)
		else $error("tx clock enable differs from lock");
	a_pwrdn_halt: assert property (pwrdn_pin [*5] |-> !tx_clk_en)
		else $error("pll runs in power down");
	a_ready_lock: assert property (tx_ready |-> pll_locked)
		else $error("ready without lock");
	a_take_busy: assert property (s_take |=> !tx_ready)
		else $error("ready after byte taken");
	a_speed_hold: assert property (s_take |=> line_speed == $past(tx_speed))
		else $error("line speed not latched");
	a_set_one: assert property (sw_wr.wr && sw_wr.set_ones[0] && !sw_wr.clr_ones[0]
		|=> ctrl_reg[0])
		else $error("set on one failed");
	a_clr_one: assert property (sw_wr.wr && sw_wr.clr_ones[1] && !event_hw_set
		|=> !ctrl_reg[1])
		else $error("clear on one failed");
	a_no_strap: assert property (s_quiet0 |=> $stable(ctrl_reg[0]))
		else $error("contender changed without write");
	a_beta_mode: assert property (beta_interface_select [*4] |-> beta_mode)
		else $error("beta mode not followed");
endmodule

// file: sim/board_straps.sv
// board strap and crystal model
`timescale 1ns/1ps
module board_straps (
	// clock
	input  wire logic       sys_clk,
	// scenario controls
	input  wire logic [2:0] pc_cfg,
	input  wire logic       beta_off,
	input  wire logic       xtal_off,
	// pins
	output logic            beta_interface_select,
	output logic      [2:0] pc_pins,
	output logic            xtal_ok
);
	always @(posedge sys_clk) begin
		beta_interface_select <= !beta_off;
		pc_pins <= pc_cfg;
		xtal_ok <= !xtal_off;
	end
endmodule

// file: sim/testbench.sv
// random and corner-case bench for the configuration and clocking block
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin num_errors++; \
	$display("[ERR] %0t got %h exp %h", $time, a, b); end end
module testbench
	import phy_cfg_pkg::*;
;
	logic sys_clk, sys_rst, pwrdn_pin, event_hw_set, tx_valid, beta_off, xtal_off, e;
	logic beta_interface_select, xtal_ok, tx_ready, tx_line, tx_clk_en;
	logic pll_locked, pll_run_n, beta_mode;
	logic [2:0] pc_cfg, pc_pins, self_id_power_class;
	logic [7:0] tx_data, ctrl_reg, exp, s, c;
	reg_wr_t sw_wr;
	speed_t tx_speed, line_speed;
	int num_errors = 0, num_checks = 0, cyc = 0;
	board_straps i_brd (.sys_clk, .pc_cfg, .beta_off, .xtal_off, .beta_interface_select,
		.pc_pins, .xtal_ok);
	phy_cfg_clk i_dut (.sys_clk, .sys_rst, .xtal_ok, .pwrdn_pin, .beta_interface_select,
		.power_class_strap_bit0(pc_pins[0]), .power_class_strap_bit1(pc_pins[1]),
		.power_class_strap_bit2(pc_pins[2]), .sw_wr, .event_hw_set, .tx_valid, .tx_data,
		.tx_speed, .tx_ready, .tx_line, .tx_clk_en, .pll_locked, .pll_run_n, .ctrl_reg,
		.self_id_power_class, .beta_mode, .line_speed);
	function automatic logic [7:0] nx(logic [7:0] o, sv, cv, input logic ev);
		nx = (o | sv) & ~cv;
		if (ev) nx[1] = 1'b1;
	endfunction
	task automatic finish_test;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic wait_lock;
		int n = 0;
		while (pll_locked !== 1'b1 && n < 300) begin
			@(posedge sys_clk);
			n++;
		end
		#1 `CHK(tx_ready, 1'b1)
		`CHK(pll_run_n, 1'b0)
	endtask
	task automatic send(logic [7:0] d, speed_t sp);
		int n = 0, t = 0;
		logic l;
		@(posedge sys_clk);
		tx_valid <= 1'b1;
		tx_data <= d;
		tx_speed <= sp;
		do begin @(posedge sys_clk); n++; end while (tx_ready !== 1'b1 && n < 50);
		tx_valid <= 1'b0;
		l = tx_line;
		do begin
			@(posedge sys_clk);
			n++;
			if (tx_line !== l) t++;
			l = tx_line;
		end while ((tx_ready !== 1'b1 || n < 60) && n < 99);
		`CHK(t, $countones(d))
		`CHK(line_speed, sp)
	endtask
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin num_errors++; finish_test; end
	end
	initial begin
		void'($urandom(37734));
		{sys_rst, pwrdn_pin, event_hw_set, tx_valid, beta_off, xtal_off} = 6'h20;
		sw_wr = '0;
		tx_data = 8'h00;
		tx_speed = SPD_S100;
		pc_cfg = 3'($urandom);
		repeat (5) @(posedge sys_clk);
		sys_rst <= 1'b0;
		repeat (4) @(posedge sys_clk);
		#1 `CHK(self_id_power_class, pc_cfg)
		`CHK(ctrl_reg, 8'h00)
		wait_lock;
		$display("straps and lock done");
		exp = 8'h00;
		repeat (40) begin
			@(posedge sys_clk);
			s = 8'($urandom);
			c = 8'($urandom);
			e = 1'($urandom);
			sw_wr <= '{1'b1, s, c};
			event_hw_set <= e;
			exp = nx(exp, s, c, e);
			@(posedge sys_clk);
			sw_wr.wr <= 1'b0;
			event_hw_set <= 1'b0;
			#1 `CHK(ctrl_reg, exp)
		end
		$display("control byte done");
		for (int k = 0; k < 5; k++) send(8'($urandom), speed_t'(k));
		send(8'hff, SPD_S100);
		send(8'h00, SPD_S800);
		$display("transmit done");
		@(posedge sys_clk) beta_off <= 1'b1;
		repeat (6) @(posedge sys_clk);
		#1 `CHK(beta_mode, 1'b0)
		@(posedge sys_clk) beta_off <= 1'b0;
		repeat (6) @(posedge sys_clk);
		#1 `CHK(beta_mode, 1'b1)
		$display("beta mode done");
		@(posedge sys_clk) pwrdn_pin <= 1'b1;
		repeat (6) @(posedge sys_clk);
		#1 `CHK(pll_locked, 1'b0)
		`CHK(tx_ready, 1'b0)
		`CHK(tx_clk_en, 1'b0)
		@(posedge sys_clk) pwrdn_pin <= 1'b0;
		wait_lock;
		@(posedge sys_clk) xtal_off <= 1'b1;
		repeat (8) @(posedge sys_clk);
		#1 `CHK(pll_locked, 1'b0)
		`CHK(tx_clk_en, 1'b0)
		@(posedge sys_clk) xtal_off <= 1'b0;
		wait_lock;
		send(8'($urandom), speed_t'(3'($urandom % 5)));
		$display("power down done");
		finish_test;
	end
endmodule
bind phy_cfg_clk phy_cfg_clk_chk i_chk (.sys_clk, .sys_rst, .pwrdn_pin, .beta_interface_select,
	.sw_wr, .event_hw_set, .tx_valid, .tx_speed, .tx_ready, .tx_clk_en, .pll_locked,
	.pll_run_n, .ctrl_reg, .beta_mode, .line_speed);
